// ===== dv/bus_far_end.sv
`timescale 1ns/1ps
// Far side of the bridge: system memory and an I/O-bus target
module bus_far_end (
  // Clock, reset and answer latency
  input wire logic clock,
  input wire logic nrst,
  input wire logic [3:0] lat,
  // System bus
  input wire logic sys_valid,
  input wire cmd_translate_pkg::sys_req_s sys_req,
  output logic sys_ready,
  output logic sys_rvalid,
  output logic [63:0] sys_rdata,
  // I/O bus
  input wire logic io_out_valid,
  output logic io_out_ready
);
  logic [3:0] wait_r;
  logic [3:0] owait_r;
  logic pend_r;
  logic [31:0] raddr_r;

  // Accept after lat cycles; read data follows lat cycles after acceptance
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      sys_ready <= 1'h0;
      sys_rvalid <= 1'h0;
      sys_rdata <= 64'h0;
      io_out_ready <= 1'h0;
      wait_r <= 4'h0;
      owait_r <= 4'h0;
      pend_r <= 1'h0;
      raddr_r <= 32'h0;
    end else begin
      sys_ready <= 1'h0;
      sys_rvalid <= 1'h0;
      io_out_ready <= 1'h0;
      // Stale data keeps toggling, so a sample an odd number of cycles late does not match
      sys_rdata <= ~sys_rdata;
      if (sys_valid && !sys_ready && !pend_r) begin
        wait_r <= wait_r + 4'h1;
        if (wait_r >= lat) begin
          sys_ready <= 1'h1;
          wait_r <= 4'h0;
          pend_r <= sys_req.cmd inside {cmd_translate_pkg::SYS_READ,
                                        cmd_translate_pkg::SYS_IREAD};
          raddr_r <= sys_req.addr[31:0];
        end
      end else if (pend_r) begin
        wait_r <= wait_r + 4'h1;
        if (wait_r >= lat) begin
          sys_rvalid <= 1'h1;
          sys_rdata <= {raddr_r ^ 32'h5A5A_0000, raddr_r ^ 32'hA5A5_0000};
          pend_r <= 1'h0;
          wait_r <= 4'h0;
        end
      end
      if (io_out_valid && !io_out_ready) begin
        owait_r <= owait_r + 4'h1;
        if (owait_r >= lat) begin
          io_out_ready <= 1'h1;
          owait_r <= 4'h0;
        end
      end
    end
  end
endmodule : bus_far_end

// ===== dv/sysbus_iobus_cmd_translate_test.sv
`timescale 1ns/1ps
module sysbus_iobus_cmd_translate_test;
  logic clock = 1'h0;
  logic nrst, node_reset, util_wr, error_irq, force_irq, chip_interrupt_request;
  logic [31:0] util_wdata, adapter_utility_reg, io_rdata, page_map_entry;
  logic io_valid, io_ack, io_rvalid, sys_valid, sys_ready, sys_rvalid;
  logic sysin_valid, sysin_ack, io_out_valid, io_out_ready, pm_valid, ok;
  logic [15:0] page_map_index;
  logic [63:0] sys_rdata;
  logic [3:0] lat;
  cmd_translate_pkg::io_req_s io_req;
  cmd_translate_pkg::sys_req_s sys_req, got_r;
  cmd_translate_pkg::sysin_req_s sysin_req;
  cmd_translate_pkg::io_out_s io_out;
  int fails, checked;

  always #5 clock = ~clock;
  // Page map: frame number equals the index, valid bit under bench control
  assign page_map_entry = {pm_valid, 15'h0000, page_map_index};

  sysbus_iobus_cmd_translate i_sysbus_iobus_cmd_translate (.clock, .nrst,
    .node_reset, .util_wr, .util_wdata, .adapter_utility_reg, .error_irq,
    .force_irq, .chip_interrupt_request, .io_valid, .io_req, .io_ack,
    .io_rvalid, .io_rdata, .page_map_index, .page_map_entry, .sys_valid,
    .sys_req, .sys_ready, .sys_rvalid, .sys_rdata, .sysin_valid, .sysin_req,
    .sysin_ack, .io_out_valid, .io_out, .io_out_ready);
  bus_far_end i_bus_far_end (.clock, .nrst, .lat, .sys_valid, .sys_req,
    .sys_ready, .sys_rvalid, .sys_rdata, .io_out_valid, .io_out_ready);

  task automatic check(input string what, input logic [63:0] e, input logic [63:0] g);
    checked++;
    if (g !== e) begin
      fails++;
      $display("wrong value %s expected %h seen %h", what, e, g);
    end
  endtask : check

  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : finish_test

  // Bounded wait until a flag reaches the wanted level
  task automatic await(ref logic f, input logic lvl, input string what);
    int n;
    for (n = 0; f !== lvl; n++) begin
      if (n > 60) begin
        check(what, 64'h1, 64'h0);
        finish_test();
      end
      @(posedge clock);
      #1;
    end
  endtask : await

  // Hold one I/O-bus request until acknowledged or 12 cycles pass
  task automatic io_run(input cmd_translate_pkg::io_cmd_e c,
      input cmd_translate_pkg::len_e l, input logic sp, input logic [29:0] a);
    int n;
    @(negedge clock);
    io_req = '{c, l, sp, a};
    io_valid = 1'h1;
    ok = 1'h0;
    for (n = 0; n < 12 && !ok; n++) begin
      @(posedge clock);
      #1;
      ok = io_ack;
    end
    got_r = sys_req;
    check("sys valid at ack", {63'h0, ok && c != cmd_translate_pkg::IO_IDENT}, {63'h0, sys_valid});
    @(negedge clock);
    io_valid = 1'h0;
  endtask : io_run

  // Accepted DMA: command, length, address, longword enables, read data
  task automatic dma(input cmd_translate_pkg::io_cmd_e c, input cmd_translate_pkg::len_e l,
      input logic [29:0] a, input cmd_translate_pkg::sys_cmd_e ec, input logic [39:0] ea);
    logic rd;
    logic lw;
    rd = c inside {cmd_translate_pkg::IO_READ, cmd_translate_pkg::IO_RCI,
                   cmd_translate_pkg::IO_INTERLOCK_READ_CACHE_INTENT};
    lw = l == cmd_translate_pkg::LEN_LW && c != cmd_translate_pkg::IO_INTERRUPT_CMD;
    io_run(c, l, 1'h0, a);
    check("dma ack", 64'h1, {63'h0, ok});
    check("sys cmd", {61'h0, ec}, {61'h0, got_r.cmd});
    check("sys len", lw ? 64'h1 : {62'h0, l}, {62'h0, got_r.len});
    check("sys addr", {27'h0, ea[39:3]}, {27'h0, got_r.addr[39:3]});
    if (lw && !rd) begin
      check("lw enables", a[2] ? 64'h2 : 64'h1, {62'h0, got_r.lw_en});
    end
    if (rd) begin
      await(io_rvalid, 1'h1, "read return");
      if (lw) begin
        check("read data", {32'h0, got_r.addr[31:0] ^ (a[2] ? 32'h5A5A_0000 : 32'hA5A5_0000)},
              {32'h0, io_rdata});
      end
    end else begin
      await(sys_valid, 1'h0, "sys release");
    end
  endtask : dma

  task automatic refuse(input cmd_translate_pkg::io_cmd_e c, input logic sp, input logic [29:0] a);
    io_run(c, cmd_translate_pkg::LEN_LW, sp, a);
    check("refused ack", 64'h0, {63'h0, ok});
  endtask : refuse

  // System-bus I/O command; ec is the expected I/O-bus command
  task automatic sysio(input cmd_translate_pkg::sys_cmd_e c, input cmd_translate_pkg::len_e l,
      input logic e, input cmd_translate_pkg::io_cmd_e ec);
    int n;
    @(negedge clock);
    sysin_req = '{c, l, 30'h0012_3454};
    sysin_valid = 1'h1;
    ok = 1'h0;
    for (n = 0; n < 12 && !ok; n++) begin
      @(posedge clock);
      #1;
      ok = sysin_ack;
    end
    check("sysin ack", {63'h0, e}, {63'h0, ok});
    if (ok) begin
      check("io out", {28'h0, ec, l, 30'h0012_3454}, {28'h0, io_out});
      check("io out valid", 64'h1, {63'h0, io_out_valid});
    end
    @(negedge clock);
    sysin_valid = 1'h0;
    await(io_out_valid, 1'h0, "io out release");
  endtask : sysio

  task automatic set_util(input logic [31:0] v);
    @(negedge clock);
    util_wr = 1'h1;
    util_wdata = v;
    @(negedge clock);
    util_wr = 1'h0;
    check("utility reg", {32'h0, v}, {32'h0, adapter_utility_reg});
  endtask : set_util

  task automatic t_reset;
    check("utility reset", 64'h0, {32'h0, adapter_utility_reg});
    check("idle outputs", 64'h0, {61'h0, io_ack, sys_valid, sysin_ack});
    $display("test reset done");
  endtask : t_reset

  task automatic t_compat;
    cmd_translate_pkg::io_cmd_e ic[7] = '{cmd_translate_pkg::IO_READ,
      cmd_translate_pkg::IO_RCI, cmd_translate_pkg::IO_INTERLOCK_READ_CACHE_INTENT, cmd_translate_pkg::IO_WRITE,
      cmd_translate_pkg::IO_WCI, cmd_translate_pkg::IO_MASKED_WRITE_CACHE_INTENT, cmd_translate_pkg::IO_UNLOCK_MASKED_WRITE_CACHE_INTENT};
    cmd_translate_pkg::sys_cmd_e sc[7] = '{cmd_translate_pkg::SYS_READ,
      cmd_translate_pkg::SYS_READ, cmd_translate_pkg::SYS_IREAD, cmd_translate_pkg::SYS_WMASK,
      cmd_translate_pkg::SYS_WMASK, cmd_translate_pkg::SYS_WMASK, cmd_translate_pkg::SYS_UWMASK};
    logic [29:0] a;
    for (int i = 0; i < 7; i++) begin
      for (int k = 0; k < 3; k++) begin
        lat = 4'(i + k);
        a = (k == 0) ? 30'h1FFF_FFF4 : 30'h0000_0A38 + 30'(i);
        dma(ic[i], cmd_translate_pkg::len_e'(k), a, sc[i], {11'h000, a[28:0]});
      end
    end
    dma(cmd_translate_pkg::IO_WRITE, cmd_translate_pkg::LEN_LW, 30'h0000_0100,
        cmd_translate_pkg::SYS_WMASK, 40'h00_0000_0100);
    dma(cmd_translate_pkg::IO_INTERRUPT_CMD, cmd_translate_pkg::LEN_LW, 30'h0000_0040,
        cmd_translate_pkg::SYS_INTERRUPT_CMD, 40'h00_0000_0040);
    $display("test compat done");
  endtask : t_compat

  task automatic t_refused;
    refuse(cmd_translate_pkg::IO_INVALIDATE_CMD, 1'h0, 30'h0000_0100);
    refuse(cmd_translate_pkg::IO_BROADCAST_CMD, 1'h0, 30'h0000_0100);
    refuse(cmd_translate_pkg::IO_IDENT, 1'h0, 30'h0000_0100);
    refuse(cmd_translate_pkg::IO_READ, 1'h1, 30'h0000_0100);
    refuse(cmd_translate_pkg::IO_WRITE, 1'h0, 30'h2000_0000);
    for (int i = 0; i < 3; i++) begin
      {error_irq, force_irq, chip_interrupt_request} = 3'h4 >> i;
      io_run(cmd_translate_pkg::IO_IDENT, cmd_translate_pkg::LEN_LW, 1'h0, 30'h0);
      check("identify ack", 64'h1, {63'h0, ok});
    end
    {error_irq, force_irq, chip_interrupt_request} = 3'h0;
    $display("test refused done");
  endtask : t_refused

  task automatic t_map;
    set_util(32'h0004_0000);
    dma(cmd_translate_pkg::IO_READ, cmd_translate_pkg::LEN_LW, 30'h0000_1234,
        cmd_translate_pkg::SYS_READ, 40'h00_0000_1234);
    dma(cmd_translate_pkg::IO_MASKED_WRITE_CACHE_INTENT, cmd_translate_pkg::LEN_QW, 30'h01FF_FE08,
        cmd_translate_pkg::SYS_WMASK, {15'h0, 16'hFFFF, 9'h008});
    refuse(cmd_translate_pkg::IO_READ, 1'h0, 30'h0200_0000);
    pm_valid = 1'h0;
    refuse(cmd_translate_pkg::IO_WRITE, 1'h0, 30'h0000_1234);
    pm_valid = 1'h1;
    set_util(32'h0002_0000);
    refuse(cmd_translate_pkg::IO_READ, 1'h0, 30'h0000_1234);
    @(negedge clock);
    node_reset = 1'h1;
    @(negedge clock);
    node_reset = 1'h0;
    check("node reset", 64'h0, {32'h0, adapter_utility_reg});
    dma(cmd_translate_pkg::IO_READ, cmd_translate_pkg::LEN_QW, 30'h1000_1234,
        cmd_translate_pkg::SYS_READ, 40'h00_1000_1234);
    $display("test map done");
  endtask : t_map

  task automatic t_sysside;
    sysio(cmd_translate_pkg::SYS_READ, cmd_translate_pkg::LEN_LW, 1'h1,
          cmd_translate_pkg::IO_READ);
    sysio(cmd_translate_pkg::SYS_IREAD, cmd_translate_pkg::LEN_LW, 1'h1,
          cmd_translate_pkg::IO_INTERLOCK_READ_CACHE_INTENT);
    lat = 4'h3;
    sysio(cmd_translate_pkg::SYS_WMASK, cmd_translate_pkg::LEN_LW, 1'h1,
          cmd_translate_pkg::IO_MASKED_WRITE_CACHE_INTENT);
    sysio(cmd_translate_pkg::SYS_UWMASK, cmd_translate_pkg::LEN_LW, 1'h1,
          cmd_translate_pkg::IO_UNLOCK_MASKED_WRITE_CACHE_INTENT);
    sysio(cmd_translate_pkg::SYS_IDENT, cmd_translate_pkg::LEN_QW, 1'h1,
          cmd_translate_pkg::IO_IDENT);
    sysio(cmd_translate_pkg::SYS_INTERRUPT_CMD, cmd_translate_pkg::LEN_LW, 1'h0,
          cmd_translate_pkg::IO_READ);
    sysio(cmd_translate_pkg::SYS_IMPLIED_VECTOR_IRQ, cmd_translate_pkg::LEN_LW, 1'h0,
          cmd_translate_pkg::IO_READ);
    for (int k = 1; k < 4; k++) begin
      sysio(cmd_translate_pkg::SYS_READ, cmd_translate_pkg::len_e'(k), 1'h0,
            cmd_translate_pkg::IO_READ);
      sysio(cmd_translate_pkg::SYS_WMASK, cmd_translate_pkg::len_e'(k), 1'h0,
            cmd_translate_pkg::IO_READ);
    end
    $display("test system side done");
  endtask : t_sysside

  initial begin
    {nrst, node_reset, util_wr, error_irq, force_irq, chip_interrupt_request} = 6'h00;
    {io_valid, sysin_valid, lat, util_wdata} = 38'h0;
    io_req = '0;
    sysin_req = '0;
    pm_valid = 1'h1;
    fails = 0;
    checked = 0;
    repeat (6) @(negedge clock);
    nrst = 1'h1;
    t_reset();
    t_compat();
    t_refused();
    t_map();
    t_sysside();
    finish_test();
  end
endmodule : sysbus_iobus_cmd_translate_test

// ===== hdl/cmd_translate_cfg.svh
`ifndef CMD_TRANSLATE_CFG_SVH
`define CMD_TRANSLATE_CFG_SVH

// Mode field inside the adapter utility register
`define UTIL_MODE_HI 19
`define UTIL_MODE_LO 17
`define UTIL_RESET 32'h0000_0000
`define MODE_COMPAT 3'h0
`define MODE_MAP512 3'h2

// Address layout
`define IO_AW 30
`define SYS_AW 40
`define IO_TOP_BIT 29
`define COMPAT_HI 28
`define MAP512_CHK_LO 25
`define MAP512_IDX_HI 24
`define MAP512_IDX_LO 9
`define PAGE_OFS_HI 8
`define ENTRY_VALID_BIT 31
`define ENTRY_PFN_HI 29
`define LW_SEL_BIT 2

`endif

// ===== hdl/cmd_translate_pkg.sv
package cmd_translate_pkg;

  // Transfer length of a bus command
  typedef enum logic [1:0] {
    LEN_LW = 2'b00,
    LEN_QW = 2'b01,
    LEN_OW = 2'b10,
    LEN_HW = 2'b11
  } len_e;

  // I/O-bus commands
  typedef enum logic [3:0] {
    IO_READ = 4'b0000,
    IO_RCI = 4'b0001,
    IO_INTERLOCK_READ_CACHE_INTENT = 4'b0010,
    IO_WRITE = 4'b0011,
    IO_WCI = 4'b0100,
    IO_MASKED_WRITE_CACHE_INTENT = 4'b0101,
    IO_UNLOCK_MASKED_WRITE_CACHE_INTENT = 4'b0110,
    IO_INTERRUPT_CMD = 4'b0111,
    IO_IDENT = 4'b1000,
    IO_INVALIDATE_CMD = 4'b1001,
    IO_BROADCAST_CMD = 4'b1010
  } io_cmd_e;

  // System-bus commands
  typedef enum logic [2:0] {
    SYS_READ = 3'b000,
    SYS_IREAD = 3'b001,
    SYS_WMASK = 3'b010,
    SYS_UWMASK = 3'b011,
    SYS_INTERRUPT_CMD = 3'b100,
    SYS_IDENT = 3'b101,
    SYS_IMPLIED_VECTOR_IRQ = 3'b110
  } sys_cmd_e;

  // Request arriving from an I/O-bus master
  typedef struct packed {
    io_cmd_e cmd;
    len_e len;
    logic io_space;
    logic [29:0] addr;
  } io_req_s;

  // Request placed on the system bus
  typedef struct packed {
    sys_cmd_e cmd;
    len_e len;
    logic [1:0] lw_en;
    logic [39:0] addr;
  } sys_req_s;

  // Request arriving from a system-bus commander
  typedef struct packed {
    sys_cmd_e cmd;
    len_e len;
    logic [29:0] addr;
  } sysin_req_s;

  // Request forwarded onto the I/O bus
  typedef struct packed {
    io_cmd_e cmd;
    len_e len;
    logic [29:0] addr;
  } io_out_s;

endpackage : cmd_translate_pkg

// ===== hdl/dma_addr_map.sv
`timescale 1ns/1ps
`include "cmd_translate_cfg.svh"

module dma_addr_map #(
  parameter int IO_AW = `IO_AW,
  parameter int SYS_AW = `SYS_AW
) (
  // Selected mode and untranslated address
  input wire logic [2:0] mode,
  input wire logic is_dma,
  input wire logic [IO_AW-1:0] io_addr,
  // Page map lookup
  output logic [15:0] page_map_index,
  input wire logic [31:0] page_map_entry,
  // Result
  output logic [SYS_AW-1:0] sys_addr,
  output logic abort
);

  // Translation; only DMA transfers are mapped, others pass with zero extension
  always_comb begin
    page_map_index = io_addr[`MAP512_IDX_HI:`MAP512_IDX_LO];
    sys_addr = '0;
    abort = 1'b0;
    if (!is_dma) begin
      sys_addr[IO_AW-1:0] = io_addr;
    end else if (mode == `MODE_COMPAT) begin
      // bit 29 zero, upper bits zero
      sys_addr[`COMPAT_HI:0] = io_addr[`COMPAT_HI:0];
      abort = io_addr[`IO_TOP_BIT];
    end else if (mode == `MODE_MAP512) begin
      sys_addr[`PAGE_OFS_HI:0] = io_addr[`PAGE_OFS_HI:0];
      sys_addr[SYS_AW-2:`PAGE_OFS_HI+1] = page_map_entry[`ENTRY_PFN_HI:0];
      abort = (|io_addr[`IO_TOP_BIT:`MAP512_CHK_LO]) | ~page_map_entry[`ENTRY_VALID_BIT];
    end else begin
      // Page sizes this front end does not map are refused
      abort = 1'b1;
    end
  end

endmodule : dma_addr_map

// ===== hdl/sysbus_iobus_cmd_translate.sv
`timescale 1ns/1ps
`include "cmd_translate_cfg.svh"
// Behaviour
// - Mode field at utility register bits 19:17 selects DMA address translation.
// - Power-up and node reset restore compatibility mode.
// - Compatibility mode maps I/O memory directly to lowest 512 Mbytes.
// - Translation applies only to DMA transfers; others pass untranslated.
// - I/O-bus reads, writes and interrupt commands to system I/O space are refused.
// - Plain read or read with cache intent becomes system read.
// - Interlock read with cache intent becomes system interlock read.
// - Longword reads issue quadword reads; only requested longword returns.
// - Write, cache-intent write, masked write become system write-mask.
// - Unlock masked write becomes system unlock write-mask.
// - Longword writes become quadword writes masking the unused longword.
// - Identify without a cause, invalidate and broadcast from I/O bus get no acknowledge.
// - Identify answered only on error, force or chip interrupt request.
// - Quad, octa, hexword (except identify), interrupt and implied-vector system commands refused.
// - System longword interlock read becomes I/O interlock read cache intent.
// - System longword masked write becomes I/O masked write cache intent.
// - System longword unlock masked write becomes I/O unlock variant.
// - Compatibility needs bit 29 zero, copies 28:0, zeroes 39:29.
// - 512-byte mode indexes map with bits 24:9, aborts if invalid.
module sysbus_iobus_cmd_translate (
  // Clock and reset
  input wire logic clock,
  input wire logic nrst,
  input wire logic node_reset,
  // Utility register load port
  input wire logic util_wr,
  input wire logic [31:0] util_wdata,
  output logic [31:0] adapter_utility_reg,
  // Identify answer conditions
  input wire logic error_irq,
  input wire logic force_irq,
  input wire logic chip_interrupt_request,
  // I/O-bus DMA requests in
  input wire logic io_valid,
  input wire cmd_translate_pkg::io_req_s io_req,
  output logic io_ack,
  output logic io_rvalid,
  output logic [31:0] io_rdata,
  // Page map lookup
  output logic [15:0] page_map_index,
  input wire logic [31:0] page_map_entry,
  // System-bus requests out
  output logic sys_valid,
  output cmd_translate_pkg::sys_req_s sys_req,
  input wire logic sys_ready,
  input wire logic sys_rvalid,
  input wire logic [63:0] sys_rdata,
  // System-bus I/O requests in
  input wire logic sysin_valid,
  input wire cmd_translate_pkg::sysin_req_s sysin_req,
  output logic sysin_ack,
  // I/O-bus requests out
  output logic io_out_valid,
  output cmd_translate_pkg::io_out_s io_out,
  input wire logic io_out_ready
);

  typedef enum logic [1:0] {
    DMA_IDLE = 2'b00,
    DMA_ISSUE = 2'b01,
    DMA_WAIT = 2'b10
  } dma_state_e;

  typedef enum logic [0:0] {
    FWD_IDLE = 1'b0,
    FWD_BUSY = 1'b1
  } fwd_state_e;

  // Longword requests are widened to a quadword
  function automatic cmd_translate_pkg::len_e widen(input cmd_translate_pkg::len_e len);
    widen = (len == cmd_translate_pkg::LEN_LW) ? cmd_translate_pkg::LEN_QW : len;
  endfunction : widen

  // Read commands from the I/O bus
  function automatic logic io_is_read(input cmd_translate_pkg::io_cmd_e cmd);
    io_is_read = (cmd == cmd_translate_pkg::IO_READ) || (cmd == cmd_translate_pkg::IO_RCI) ||
      (cmd == cmd_translate_pkg::IO_INTERLOCK_READ_CACHE_INTENT);
  endfunction : io_is_read

  logic [31:0] util_r, util_nxt;
  logic [2:0] mode;
  dma_state_e dma_r, dma_nxt;
  fwd_state_e fwd_r, fwd_nxt;
  cmd_translate_pkg::sys_req_s sys_r, sys_nxt;
  cmd_translate_pkg::io_out_s out_r, out_nxt;
  logic io_ack_r, io_ack_nxt;
  logic rvalid_r, rvalid_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic lw_hi_r, lw_hi_nxt;
  logic lw_rd_r, lw_rd_nxt;
  logic sysin_ack_r, sysin_ack_nxt;
  logic map_abort;
  logic [39:0] map_addr;
  logic is_dma;
  logic dma_ok;
  logic [1:0] dma_kind;
  cmd_translate_pkg::sys_cmd_e dma_cmd;

  // Utility register; node reset wins over a load so the default mode is restored
  always_comb begin
    util_nxt = util_r;
    if (node_reset) begin
      util_nxt = `UTIL_RESET;
    end else if (util_wr) begin
      util_nxt = util_wdata;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      util_r <= `UTIL_RESET;
    end else begin
      util_r <= util_nxt;
    end
  end

  assign mode = util_r[`UTIL_MODE_HI:`UTIL_MODE_LO];
  assign adapter_utility_reg = util_r;

  assign is_dma = io_is_read(io_req.cmd) || (io_req.cmd == cmd_translate_pkg::IO_WRITE) ||
    (io_req.cmd == cmd_translate_pkg::IO_WCI) || (io_req.cmd == cmd_translate_pkg::IO_MASKED_WRITE_CACHE_INTENT) ||
    (io_req.cmd == cmd_translate_pkg::IO_UNLOCK_MASKED_WRITE_CACHE_INTENT);

  dma_addr_map i_dma_addr_map (
    .mode(mode),
    .is_dma(is_dma),
    .io_addr(io_req.addr),
    .page_map_index(page_map_index),
    .page_map_entry(page_map_entry),
    .sys_addr(map_addr),
    .abort(map_abort)
  );

  // Command decode for the I/O-bus side; kind 1 = forward, 2 = identify answer
  always_comb begin
    dma_cmd = cmd_translate_pkg::SYS_READ;
    dma_kind = 2'h0;
    case (io_req.cmd)
      cmd_translate_pkg::IO_READ, cmd_translate_pkg::IO_RCI: begin
        dma_kind = 2'h1;
      end
      cmd_translate_pkg::IO_INTERLOCK_READ_CACHE_INTENT: begin
        dma_cmd = cmd_translate_pkg::SYS_IREAD;
        dma_kind = 2'h1;
      end
      cmd_translate_pkg::IO_WRITE, cmd_translate_pkg::IO_WCI, cmd_translate_pkg::IO_MASKED_WRITE_CACHE_INTENT: begin
        dma_cmd = cmd_translate_pkg::SYS_WMASK;
        dma_kind = 2'h1;
      end
      cmd_translate_pkg::IO_UNLOCK_MASKED_WRITE_CACHE_INTENT: begin
        dma_cmd = cmd_translate_pkg::SYS_UWMASK;
        dma_kind = 2'h1;
      end
      cmd_translate_pkg::IO_INTERRUPT_CMD: begin
        dma_cmd = cmd_translate_pkg::SYS_INTERRUPT_CMD;
        dma_kind = 2'h1;
      end
      cmd_translate_pkg::IO_IDENT: begin
        dma_kind = (error_irq || force_irq || chip_interrupt_request) ? 2'h2 : 2'h0;
      end
      default: begin
        dma_kind = 2'h0;
      end
    endcase
  end

  // system I/O space refused, aborted maps refused
  assign dma_ok = (dma_kind == 2'h1) && !io_req.io_space && !map_abort;

  // DMA sequencer: writes are acknowledged at acceptance, reads return data later
  always_comb begin
    dma_nxt = dma_r;
    sys_nxt = sys_r;
    io_ack_nxt = 1'b0;
    rvalid_nxt = 1'b0;
    rdata_nxt = rdata_r;
    lw_hi_nxt = lw_hi_r;
    lw_rd_nxt = lw_rd_r;
    case (dma_r)
      DMA_IDLE: begin
        if (io_valid && dma_ok) begin
          sys_nxt.cmd = dma_cmd;
          sys_nxt.len = (dma_cmd == cmd_translate_pkg::SYS_INTERRUPT_CMD) ? io_req.len : widen(io_req.len);
          sys_nxt.addr = map_addr;
          sys_nxt.lw_en = 2'h3;
          if (io_req.len == cmd_translate_pkg::LEN_LW) begin
            sys_nxt.lw_en = io_req.addr[`LW_SEL_BIT] ? 2'h2 : 2'h1;
          end
          lw_hi_nxt = io_req.addr[`LW_SEL_BIT];
          lw_rd_nxt = io_is_read(io_req.cmd);
          io_ack_nxt = 1'b1;
          dma_nxt = DMA_ISSUE;
        end else if (io_valid && (dma_kind == 2'h2)) begin
          io_ack_nxt = 1'b1;
        end
      end
      DMA_ISSUE: begin
        if (sys_ready) begin
          dma_nxt = lw_rd_r ? DMA_WAIT : DMA_IDLE;
        end
      end
      DMA_WAIT: begin
        if (sys_rvalid) begin
          rdata_nxt = lw_hi_r ? sys_rdata[63:32] : sys_rdata[31:0];
          rvalid_nxt = 1'b1;
          dma_nxt = DMA_IDLE;
        end
      end
      default: begin
        dma_nxt = DMA_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      dma_r <= DMA_IDLE;
      sys_r <= '0;
      io_ack_r <= 1'b0;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      lw_hi_r <= 1'b0;
      lw_rd_r <= 1'b0;
    end else begin
      dma_r <= dma_nxt;
      sys_r <= sys_nxt;
      io_ack_r <= io_ack_nxt;
      rvalid_r <= rvalid_nxt;
      rdata_r <= rdata_nxt;
      lw_hi_r <= lw_hi_nxt;
      lw_rd_r <= lw_rd_nxt;
    end
  end

  assign sys_valid = (dma_r == DMA_ISSUE);
  assign sys_req = sys_r;
  assign io_ack = io_ack_r;
  assign io_rvalid = rvalid_r;
  assign io_rdata = rdata_r;

  // System-bus to I/O-bus forwarding; only longword and identify commands pass
  always_comb begin
    fwd_nxt = fwd_r;
    out_nxt = out_r;
    sysin_ack_nxt = 1'b0;
    case (fwd_r)
      FWD_IDLE: begin
        if (sysin_valid) begin
          out_nxt.len = sysin_req.len;
          out_nxt.addr = sysin_req.addr;
          sysin_ack_nxt = 1'b1;
          fwd_nxt = FWD_BUSY;
          case (sysin_req.cmd)
            cmd_translate_pkg::SYS_READ: out_nxt.cmd = cmd_translate_pkg::IO_READ;
            cmd_translate_pkg::SYS_IREAD: out_nxt.cmd = cmd_translate_pkg::IO_INTERLOCK_READ_CACHE_INTENT;
            cmd_translate_pkg::SYS_WMASK: out_nxt.cmd = cmd_translate_pkg::IO_MASKED_WRITE_CACHE_INTENT;
            cmd_translate_pkg::SYS_UWMASK: out_nxt.cmd = cmd_translate_pkg::IO_UNLOCK_MASKED_WRITE_CACHE_INTENT;
            cmd_translate_pkg::SYS_IDENT: out_nxt.cmd = cmd_translate_pkg::IO_IDENT;
            default: begin
              sysin_ack_nxt = 1'b0;
              fwd_nxt = FWD_IDLE;
            end
          endcase
          if ((sysin_req.len != cmd_translate_pkg::LEN_LW) &&
              (sysin_req.cmd != cmd_translate_pkg::SYS_IDENT)) begin
            sysin_ack_nxt = 1'b0;
            fwd_nxt = FWD_IDLE;
            out_nxt = out_r;
          end
        end
      end
      FWD_BUSY: begin
        if (io_out_ready) begin
          fwd_nxt = FWD_IDLE;
        end
      end
      default: begin
        fwd_nxt = FWD_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      fwd_r <= FWD_IDLE;
      out_r <= '0;
      sysin_ack_r <= 1'b0;
    end else begin
      fwd_r <= fwd_nxt;
      out_r <= out_nxt;
      sysin_ack_r <= sysin_ack_nxt;
    end
  end

  assign io_out_valid = (fwd_r == FWD_BUSY);
  assign io_out = out_r;
  assign sysin_ack = sysin_ack_r;

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!nrst);

  chk_node_reset_mode: assert property (node_reset |=> mode == `MODE_COMPAT)
    else $error("mode not restored by node reset");
  chk_unsup_no_ack: assert property ((dma_r == DMA_IDLE) && io_valid &&
    (io_req.cmd inside {cmd_translate_pkg::IO_INVALIDATE_CMD, cmd_translate_pkg::IO_BROADCAST_CMD}) |=> !io_ack)
    else $error("unsupported I/O command acknowledged");
  // identify answer only with a cause
  chk_ident_cause: assert property ((dma_r == DMA_IDLE) && io_valid &&
    (io_req.cmd == cmd_translate_pkg::IO_IDENT) |=>
    io_ack == $past(error_irq || force_irq || chip_interrupt_request))
    else $error("identify answer mismatch");
  chk_io_space: assert property (io_valid && io_req.io_space |=> !io_ack)
    else $error("I/O space access acknowledged");
  chk_compat_addr: assert property (io_ack && $past(mode == `MODE_COMPAT && is_dma) |->
    sys_req.addr[39:29] == 11'h000 && sys_req.addr[28:0] == $past(io_req.addr[28:0]))
    else $error("compatibility address wrong");
  chk_lw_widen: assert property ((dma_r == DMA_IDLE) && io_valid && dma_ok &&
    io_is_read(io_req.cmd) && io_req.len == cmd_translate_pkg::LEN_LW |=>
    sys_valid && sys_req.len == cmd_translate_pkg::LEN_QW)
    else $error("longword read not widened");
  chk_lw_mask: assert property ($rose(sys_valid) &&
    sys_valid && sys_req.cmd == cmd_translate_pkg::SYS_WMASK &&
    $past(io_req.len) == cmd_translate_pkg::LEN_LW |->
    sys_req.lw_en inside {2'h1, 2'h2})
    else $error("longword write mask wrong");
  chk_wide_refused: assert property ((fwd_r == FWD_IDLE) && sysin_valid &&
    sysin_req.len != cmd_translate_pkg::LEN_LW && sysin_req.cmd != cmd_translate_pkg::SYS_IDENT
    |=> !sysin_ack && !io_out_valid)
    else $error("wide system command accepted");
  chk_iread_fwd: assert property ((fwd_r == FWD_IDLE) && sysin_valid &&
    sysin_req.cmd == cmd_translate_pkg::SYS_IREAD && sysin_req.len == cmd_translate_pkg::LEN_LW
    |=> io_out_valid && io_out.cmd == cmd_translate_pkg::IO_INTERLOCK_READ_CACHE_INTENT)
    else $error("interlock read not forwarded");
  chk_map_abort: assert property ((dma_r == DMA_IDLE) && io_valid && is_dma &&
    mode == `MODE_MAP512 && !page_map_entry[`ENTRY_VALID_BIT] |=> !io_ack ##1 !sys_valid)
    else $error("invalid page map entry used");

  cov_dma_read: cover property (sys_valid && lw_rd_r ##[1:20] io_rvalid);
  cov_dma_write: cover property (io_ack && sys_req.cmd == cmd_translate_pkg::SYS_WMASK);
  cov_sys_fwd: cover property (io_out_valid && io_out_ready);

endmodule : sysbus_iobus_cmd_translate
